// >>> pidfc_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pidfc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input logic clock_i,
   input logic rst_n_i,
   pidfc_stream_if.snk fill_s,
   pidfc_stream_if.src drain_s
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [PW:0] count_ff;
   logic push;
   logic pop;

   function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] p);
      step_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   assign fill_s.ready = (count_ff != (PW + 1)'(DEPTH));
   assign drain_s.valid = (count_ff != '0);
   assign drain_s.data = mem_ff[rd_ptr_ff];
   assign push = fill_s.valid && fill_s.ready;
   assign pop = drain_s.valid && drain_s.ready;

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= fill_s.data;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (push) wr_ptr_ff <= step_ptr(wr_ptr_ff);
         if (pop) rd_ptr_ff <= step_ptr(rd_ptr_ff);
         if (push && !pop) count_ff <= count_ff + 1'b1;
         else if (pop && !push) count_ff <= count_ff - 1'b1;
      end
   end
endmodule // pidfc_fifo

// >>> pidfc_pid_model.sv
// Regulator-side model: takes pairs promptly, slowly or not at all
`timescale 1ns/1ps
module pidfc_pid_model
   import pidfc_pkg::*;
(
   input logic clock_i,
   input logic rst_n_i,
   input logic [1:0] mode_i,
   input logic pid_valid_i,
   input logic signed [VAL_W-1:0] pid_feedback_i,
   input logic signed [VAL_W-1:0] pid_reference_i,
   output logic pid_ready_o
);
   logic [31:0] got_q[$];
   logic [1:0] cnt_ff;
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pid_ready_o <= 1'b0;
         cnt_ff <= 2'h0;
         got_q.delete();
      end else begin
         if (pid_valid_i && pid_ready_o) begin
            got_q.push_back({pid_feedback_i, pid_reference_i});
         end
         cnt_ff <= cnt_ff + 2'h1;
         pid_ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && cnt_ff == 2'h3);
      end
   end
endmodule // pidfc_pid_model

// >>> pidfc_pkg.sv
// Constants, codes and types shared by the feedback combiner design files
package pidfc_pkg;

   localparam int VAL_W = 16;
   localparam int ADC_W = 12;
   localparam int GAIN_W = 16;
   localparam int GAIN_FRAC = 8;
   localparam int ALPHA_W = 16;
   localparam int ACC_W = 32;
   localparam int RAD_W = 30;
   localparam int ROOT_W = 15;
   localparam int REM_W = 18;
   localparam int PAIR_W = 32;
   localparam int FIFO_DEPTH = 8;

   // Lowpass corner equals one over the time constant
   localparam real LP_TC_EXAMPLE_S = 0.1;
   localparam real LP_CORNER_EXAMPLE_RAD_S = 1.0 / LP_TC_EXAMPLE_S;

   // Square root walks one result bit per clock
   localparam logic [3:0] ROOT_STEPS = 4'hf;

   localparam logic CONV_LINEAR = 1'b0;
   localparam logic CONV_ROOT = 1'b1;

   localparam logic [3:0] COMB_MIN = 4'h0;
   localparam logic [3:0] COMB_MAX = 4'h1;
   localparam logic [3:0] COMB_SUM = 4'h2;
   localparam logic [3:0] COMB_DIFF = 4'h3;
   localparam logic [3:0] COMB_AVG = 4'h4;
   localparam logic [3:0] COMB_ZMIN = 4'h5;
   localparam logic [3:0] COMB_ZMAX = 4'h6;
   localparam logic [3:0] COMB_FB1 = 4'h7;
   localparam logic [3:0] COMB_FB2 = 4'h8;

   localparam logic RST_CONV = CONV_LINEAR;
   localparam logic [3:0] RST_COMB = COMB_MAX;
   localparam logic [31:0] RST_FILTER = 32'h0000_0000;
   localparam logic [15:0] RST_VALUE = 16'h0000;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_START,
      ST_ROOT,
      ST_COMBINE,
      ST_PUSH
   } pidfc_state_t;

endpackage

// >>> pidfc_sqrt.sv
// Bit-serial integer square root, one result bit per clock
`timescale 1ns/1ps
module pidfc_sqrt
   import pidfc_pkg::*;
(
   input logic clock_i,
   input logic rst_n_i,
   input logic start_i,
   input logic [RAD_W-1:0] radicand_i,
   output logic [ROOT_W-1:0] root_o,
   output logic done_o
);
   logic [RAD_W-1:0] rad_ff;
   logic [REM_W-1:0] rem_ff;
   logic [ROOT_W-1:0] root_ff;
   logic [3:0] cnt_ff;
   logic busy_ff;
   logic done_ff;
   logic [REM_W-1:0] rem_shift;
   logic [REM_W-1:0] trial;
   logic fits;

   assign rem_shift = {rem_ff[REM_W-3:0], rad_ff[RAD_W-1 -: 2]};
   assign trial = {1'b0, root_ff, 2'b01};
   assign fits = (rem_shift >= trial);
   assign root_o = root_ff;
   assign done_o = done_ff;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rad_ff <= '0;
         rem_ff <= '0;
         root_ff <= '0;
         cnt_ff <= 4'h0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (start_i) begin
         rad_ff <= radicand_i;
         rem_ff <= '0;
         root_ff <= '0;
         cnt_ff <= 4'h0;
         busy_ff <= 1'b1;
         done_ff <= 1'b0;
      end else if (busy_ff) begin
         rad_ff <= {rad_ff[RAD_W-3:0], 2'b00};
         rem_ff <= fits ? (rem_shift - trial) : rem_shift;
         root_ff <= {root_ff[ROOT_W-2:0], fits};
         cnt_ff <= cnt_ff + 4'h1;
         busy_ff <= (cnt_ff != ROOT_STEPS - 4'h1);
         done_ff <= (cnt_ff == ROOT_STEPS - 4'h1);
      end else begin
         done_ff <= 1'b0;
      end
   end
endmodule // pidfc_sqrt

// >>> pidfc_stream_if.sv
// Valid/ready stream carrying feedback and reference pairs between modules
`timescale 1ns/1ps
interface pidfc_stream_if #(
   parameter int WIDTH = 32
);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> pidfc_top.sv
// Feedback front end: channel sums, lowpass, root conversion, combine, FIFO
`timescale 1ns/1ps

module pidfc_top
   import pidfc_pkg::*;
(
   input logic clock_i,
   input logic rst_n_i,
   input logic cfg_write_i,
   input logic feedback_conversion_select_i,
   input logic [3:0] dual_feedback_combine_select_i,
   input logic [ALPHA_W-1:0] filter_alpha_i,
   input logic [GAIN_W-1:0] analog1_gain_i,
   input logic [GAIN_W-1:0] analog2_gain_i,
   input logic sample_strobe_i,
   input logic signed [VAL_W-1:0] bus_feedback1_i,
   input logic signed [VAL_W-1:0] bus_feedback2_i,
   input logic [ADC_W-1:0] analog1_i,
   input logic [ADC_W-1:0] analog2_i,
   input logic signed [VAL_W-1:0] setpoint1_i,
   input logic signed [VAL_W-1:0] setpoint2_i,
   input logic signed [VAL_W-1:0] remote_ref_i,
   input logic pid_ready_i,
   output logic sample_ready_o,
   output logic sample_drop_o,
   output logic pid_valid_o,
   output logic signed [VAL_W-1:0] pid_feedback_o,
   output logic signed [VAL_W-1:0] pid_reference_o,
   output logic signed [VAL_W-1:0] display_feedback_o,
   output logic zone_root_warn_o
);

   // Saturate a wide signed value into the feedback range
   function automatic logic signed [VAL_W-1:0] sat16(input logic signed [21:0] v);
      if (v > 22'sd32767) sat16 = 16'sh7fff;
      else if (v < -22'sd32768) sat16 = 16'sh8000;
      else sat16 = v[VAL_W-1:0];
   endfunction

   // Scaled analog term, gain has GAIN_FRAC fraction bits
   function automatic logic signed [21:0] scale_adc(input logic [ADC_W-1:0] a,
                                                    input logic [GAIN_W-1:0] g);
      logic [27:0] prod;
      prod = a * g;
      scale_adc = $signed({2'b00, prod[27:GAIN_FRAC]});
   endfunction

   // One recursive lowpass step: y += alpha * (x - y)
   function automatic logic signed [ACC_W-1:0] lp_step(input logic signed [ACC_W-1:0] y,
                                                     input logic signed [VAL_W-1:0] x,
                                                     input logic [ALPHA_W-1:0] alpha);
      logic signed [32:0] err;
      logic signed [49:0] prod;
      err = $signed({x[VAL_W-1], x, 16'h0000}) -
            $signed({y[ACC_W-1], y});
      prod = err * $signed({1'b0, alpha});
      lp_step = y + prod[47:16];
   endfunction

   // Radicand for the root unit; negative feedback clamps to zero
   function automatic logic [RAD_W-1:0] root_arg(input logic signed [VAL_W-1:0] f);
      root_arg = f[VAL_W-1] ? '0 : {f[VAL_W-2:0], 15'h0000};
   endfunction

   function automatic logic signed [21:0] ext(input logic signed [VAL_W-1:0] v);
      ext = {{6{v[VAL_W-1]}}, v};
   endfunction

   pidfc_state_t state_ff;
   pidfc_state_t nxt_state;

   logic conv_ff;
   logic [3:0] comb_ff;
   logic signed [ACC_W-1:0] filt1_ff;
   logic signed [ACC_W-1:0] filt2_ff;
   logic signed [VAL_W-1:0] cond1_ff;
   logic signed [VAL_W-1:0] cond2_ff;
   logic signed [VAL_W-1:0] pair_fb_ff;
   logic signed [VAL_W-1:0] pair_ref_ff;
   logic sample_ready_ff;
   logic sample_drop_ff;
   logic pid_valid_ff;
   logic signed [VAL_W-1:0] pid_fb_ff;
   logic signed [VAL_W-1:0] pid_ref_ff;
   logic signed [VAL_W-1:0] display_ff;
   logic warn_ff;

   logic signed [VAL_W-1:0] chan1;
   logic signed [VAL_W-1:0] chan2;
   logic signed [VAL_W-1:0] filt1_val;
   logic signed [VAL_W-1:0] filt2_val;
   logic root_start;
   logic [ROOT_W-1:0] root1;
   logic [ROOT_W-1:0] root2;
   logic root1_done;
   logic root2_done;
   logic cfg_legal;
   logic zone_mode;
   logic signed [16:0] zdiff1;
   logic signed [16:0] zdiff2;
   logic zone1_larger;
   logic zone1_smaller;
   logic zone1_pick;
   logic signed [VAL_W-1:0] fb_min;
   logic signed [VAL_W-1:0] fb_max;
   logic signed [VAL_W-1:0] fb_sum;
   logic signed [VAL_W-1:0] fb_diff;
   logic signed [VAL_W-1:0] fb_avg;
   logic signed [VAL_W-1:0] fb_zone;
   logic signed [VAL_W-1:0] comb_fb;
   logic use_sp2;
   logic signed [VAL_W-1:0] comb_ref;
   logic fifo_drain_ready;
   logic strobe_taken;

   pidfc_stream_if #(.WIDTH(PAIR_W)) fill_if ();
   pidfc_stream_if #(.WIDTH(PAIR_W)) drain_if ();

   // Configuration latch; codes above the last one are ignored
   assign cfg_legal = (dual_feedback_combine_select_i <= COMB_FB2);

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_ff <= RST_CONV;
         comb_ff <= RST_COMB;
      end else if (cfg_write_i) begin
         conv_ff <= feedback_conversion_select_i;
         if (cfg_legal) comb_ff <= dual_feedback_combine_select_i;
      end
   end

   // Channel sums of bus value and scaled analog input
   assign chan1 = sat16(ext(bus_feedback1_i) +
                        scale_adc(analog1_i, analog1_gain_i));
   assign chan2 = sat16(ext(bus_feedback2_i) +
                        scale_adc(analog2_i, analog2_gain_i));

   // No loop-mode input: the whole path always runs
   assign strobe_taken = sample_strobe_i && (state_ff == ST_IDLE);

   // Lowpass states, alpha is sample period over time constant
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         filt1_ff <= RST_FILTER;
         filt2_ff <= RST_FILTER;
      end else if (strobe_taken) begin
         filt1_ff <= lp_step(filt1_ff, chan1, filter_alpha_i);
         filt2_ff <= lp_step(filt2_ff, chan2, filter_alpha_i);
      end
   end

   assign filt1_val = filt1_ff[ACC_W-1 -: VAL_W];
   assign filt2_val = filt2_ff[ACC_W-1 -: VAL_W];

   assign root_start = (state_ff == ST_START) && (conv_ff == CONV_ROOT);

   pidfc_sqrt u_root1 (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(root_start),
      .radicand_i(root_arg(filt1_val)),
      .root_o(root1),
      .done_o(root1_done)
   );

   pidfc_sqrt u_root2 (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(root_start),
      .radicand_i(root_arg(filt2_val)),
      .root_o(root2),
      .done_o(root2_done)
   );

   // Conditioned channel values, linear or square root
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cond1_ff <= RST_VALUE;
         cond2_ff <= RST_VALUE;
      end else if (state_ff == ST_START && conv_ff == CONV_LINEAR) begin
         cond1_ff <= filt1_val;
         cond2_ff <= filt2_val;
      end else if (state_ff == ST_ROOT && root1_done) begin
         cond1_ff <= $signed({1'b0, root1});
         cond2_ff <= $signed({1'b0, root2});
      end
   end

   // Zone differences, setpoint minus feedback, signed compare
   assign zone_mode = (comb_ff == COMB_ZMIN) || (comb_ff == COMB_ZMAX);
   assign zdiff1 = $signed({setpoint1_i[VAL_W-1], setpoint1_i}) -
                   $signed({cond1_ff[VAL_W-1], cond1_ff});
   assign zdiff2 = $signed({setpoint2_i[VAL_W-1], setpoint2_i}) -
                   $signed({cond2_ff[VAL_W-1], cond2_ff});
   // Ties go to zone one in both zone modes
   assign zone1_larger = (zdiff1 >= zdiff2);
   assign zone1_smaller = (zdiff1 <= zdiff2);
   assign zone1_pick = (comb_ff == COMB_ZMIN) ? zone1_larger : zone1_smaller;

   // Combination candidates
   assign fb_min = (cond1_ff < cond2_ff) ? cond1_ff : cond2_ff;
   assign fb_max = (cond1_ff > cond2_ff) ? cond1_ff : cond2_ff;
   assign fb_sum = sat16(ext(cond1_ff) + ext(cond2_ff));
   assign fb_diff = sat16(ext(cond2_ff) - ext(cond1_ff));
   assign fb_avg = sat16((ext(cond1_ff) + ext(cond2_ff)) >>> 1);
   assign fb_zone = zone1_pick ? cond1_ff : cond2_ff;

   assign comb_fb =
      (comb_ff == COMB_MIN) ? fb_min :
      (comb_ff == COMB_SUM) ? fb_sum :
      (comb_ff == COMB_DIFF) ? fb_diff :
      (comb_ff == COMB_AVG) ? fb_avg :
      zone_mode ? fb_zone :
      (comb_ff == COMB_FB1) ? cond1_ff :
      (comb_ff == COMB_FB2) ? cond2_ff :
      fb_max;

   // Setpoint two only for a winning zone two or the second-only code
   assign use_sp2 = (zone_mode && !zone1_pick) || (comb_ff == COMB_FB2);
   assign comb_ref = sat16(ext(remote_ref_i) +
                           ext(use_sp2 ? setpoint2_i : setpoint1_i));

   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (sample_strobe_i) nxt_state = ST_START;
         end
         ST_START: begin
            nxt_state = (conv_ff == CONV_ROOT) ? ST_ROOT : ST_COMBINE;
         end
         ST_ROOT: begin
            if (root1_done) nxt_state = ST_COMBINE;
         end
         ST_COMBINE: begin
            nxt_state = ST_PUSH;
         end
         ST_PUSH: begin
            if (fill_if.ready) nxt_state = ST_IDLE;
         end
      endcase
   end

   // Ready follows the next state, so it stands for the whole idle time after the first clock out of reset
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= ST_IDLE;
         sample_ready_ff <= 1'b0;
         sample_drop_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sample_ready_ff <= (nxt_state == ST_IDLE);
         sample_drop_ff <= sample_strobe_i && (state_ff != ST_IDLE);
      end
   end

   // Feedback and reference captured as one pair
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pair_fb_ff <= RST_VALUE;
         pair_ref_ff <= RST_VALUE;
         display_ff <= RST_VALUE;
      end else if (state_ff == ST_COMBINE) begin
         pair_fb_ff <= comb_fb;
         pair_ref_ff <= comb_ref;
         display_ff <= comb_fb;
      end
   end

   // Square root on a zone function is flagged to the host
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) warn_ff <= 1'b0;
      else warn_ff <= (conv_ff == CONV_ROOT) && zone_mode;
   end

   // Pair word: feedback in the upper half, reference in the lower
   assign fill_if.valid = (state_ff == ST_PUSH);
   assign fill_if.data = {pair_fb_ff, pair_ref_ff};

   pidfc_fifo #(
      .WIDTH(PAIR_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .fill_s(fill_if.snk),
      .drain_s(drain_if.src)
   );

   // Output register stage toward the regulator
   assign fifo_drain_ready = !pid_valid_ff || pid_ready_i;
   assign drain_if.ready = fifo_drain_ready;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pid_valid_ff <= 1'b0;
         pid_fb_ff <= RST_VALUE;
         pid_ref_ff <= RST_VALUE;
      end else if (fifo_drain_ready) begin
         pid_valid_ff <= drain_if.valid;
         if (drain_if.valid) begin
            pid_fb_ff <= drain_if.data[PAIR_W-1 -: VAL_W];
            pid_ref_ff <= drain_if.data[VAL_W-1:0];
         end
      end
   end

   assign sample_ready_o = sample_ready_ff;
   assign sample_drop_o = sample_drop_ff;
   assign pid_valid_o = pid_valid_ff;
   assign pid_feedback_o = pid_fb_ff;
   assign pid_reference_o = pid_ref_ff;
   assign display_feedback_o = display_ff;
   assign zone_root_warn_o = warn_ff;

endmodule // pidfc_top

// >>> pidfc_top_asserts.sv
// Port-level assertions for the feedback combiner
`timescale 1ns/1ps
module pidfc_top_asserts
   import pidfc_pkg::*;
(
   input logic clock_i,
   input logic rst_n_i,
   input logic cfg_write_i,
   input logic feedback_conversion_select_i,
   input logic [3:0] dual_feedback_combine_select_i,
   input logic sample_strobe_i,
   input logic pid_ready_i,
   input logic sample_ready_o,
   input logic sample_drop_o,
   input logic pid_valid_o,
   input logic signed [VAL_W-1:0] pid_feedback_o,
   input logic signed [VAL_W-1:0] pid_reference_o,
   input logic zone_root_warn_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   logic conv_ff;
   logic zone_sel;
   assign zone_sel = (dual_feedback_combine_select_i == COMB_ZMIN) ||
      (dual_feedback_combine_select_i == COMB_ZMAX);
   // Conversion mode as last written
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_ff <= RST_CONV;
      end else if (cfg_write_i) begin
         conv_ff <= feedback_conversion_select_i;
      end
   end
   sequence s_take;
      sample_strobe_i && sample_ready_o;
   endsequence
   sequence s_cfg_settle;
      cfg_write_i && (dual_feedback_combine_select_i <= COMB_FB2) ##1 !cfg_write_i [*2];
   endsequence
   a_take_busy: assert property (s_take |=> !sample_ready_o [*3])
      else $error("ready returned too soon after a sample");
   a_root_busy: assert property (s_take ##1 conv_ff |-> !sample_ready_o [*8])
      else $error("root conversion finished too fast");
   a_take_answer: assert property (s_take |-> ##[1:30] pid_valid_o)
      else $error("no pair offered after a sample");
   a_pair_holds: assert property (pid_valid_o && !pid_ready_i |=> pid_valid_o &&
      $stable(pid_feedback_o) && $stable(pid_reference_o))
      else $error("offered pair changed before acceptance");
   a_reset_idle: assert property ($rose(rst_n_i) && !sample_strobe_i |=> sample_ready_o)
      else $error("not idle after reset release");
   a_drop_busy: assert property (sample_strobe_i && !sample_ready_o && $past(rst_n_i)
      |=> sample_drop_o)
      else $error("busy strobe not flagged");
   a_drop_cause: assert property (sample_drop_o |->
      $past(sample_strobe_i && !sample_ready_o))
      else $error("drop flag without a busy strobe");
   a_warn_follow: assert property (s_cfg_settle |-> ##1 zone_root_warn_o ==
      $past(feedback_conversion_select_i && zone_sel, 3))
      else $error("zone root warning wrong");
endmodule // pidfc_top_asserts
bind pidfc_top pidfc_top_asserts u_asserts (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .cfg_write_i(cfg_write_i), .feedback_conversion_select_i(feedback_conversion_select_i),
   .dual_feedback_combine_select_i(dual_feedback_combine_select_i),
   .sample_strobe_i(sample_strobe_i), .pid_ready_i(pid_ready_i),
   .sample_ready_o(sample_ready_o), .sample_drop_o(sample_drop_o), .pid_valid_o(pid_valid_o),
   .pid_feedback_o(pid_feedback_o), .pid_reference_o(pid_reference_o),
   .zone_root_warn_o(zone_root_warn_o));

// >>> pidfc_top_tb_top.sv
// Self-checking bench for the feedback combiner
`timescale 1ns/1ps
`define chk(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module pidfc_top_tb_top
   import pidfc_pkg::*;
;
   logic clock_i = 1'b0, rst_n_i = 1'b0, cfg_w = 1'b0, conv_s = 1'b0, stb = 1'b0, cv = 1'b0;
   logic [3:0] comb_s = 4'h0, code = COMB_MAX;
   logic [15:0] alpha = 16'hffff, g1 = 16'h0100, g2 = 16'h0100;
   logic signed [15:0] b1 = 16'h0000, b2 = 16'h0000, sp1 = 16'h0000;
   logic signed [15:0] sp2 = 16'h0000, rr = 16'h0000, fbo, rfo, disp;
   logic [11:0] a1 = 12'h000, a2 = 12'h000;
   logic [1:0] mode = 2'h0;
   logic rdy, s_rdy, drop, vld, warn;
   int n_fail = 0, checked = 0, seed = 35, k = 0, n = 0;
   bit fill = 1'b0;
   real y1 = 0.0, y2 = 0.0;
   logic [31:0] exp_q[$];
   int tol_q[$];
   int crn[7][8] = '{'{5, 0, 0, 1000, 3000, 2000, 3500, 100},
      '{5, 0, 0, 1000, 3000, 500, 3500, -100},
      '{6, 0, 0, 1000, 3000, 500, 3500, 0}, '{6, 0, 0, 1000, 3000, 2000, 3500, 0},
      '{2, 30000, 30000, 0, 0, 10000, 0, 30000}, '{3, -20000, 20000, 0, 0, 0, 0, -30000},
      '{4, -3, 0, 0, 0, 0, 0, 0}};
   pidfc_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_write_i(cfg_w),
      .feedback_conversion_select_i(conv_s), .dual_feedback_combine_select_i(comb_s),
      .filter_alpha_i(alpha), .analog1_gain_i(g1), .analog2_gain_i(g2), .sample_strobe_i(stb),
      .bus_feedback1_i(b1), .bus_feedback2_i(b2), .analog1_i(a1), .analog2_i(a2),
      .setpoint1_i(sp1), .setpoint2_i(sp2), .remote_ref_i(rr), .pid_ready_i(rdy),
      .sample_ready_o(s_rdy), .sample_drop_o(drop), .pid_valid_o(vld), .pid_feedback_o(fbo),
      .pid_reference_o(rfo), .display_feedback_o(disp), .zone_root_warn_o(warn));
   pidfc_pid_model u_pid (.clock_i(clock_i), .rst_n_i(rst_n_i), .mode_i(mode),
      .pid_valid_i(vld), .pid_feedback_i(fbo), .pid_reference_i(rfo), .pid_ready_o(rdy));
   function automatic int sat(int v);
      return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
   endfunction
   // Filter and root are modelled in real numbers, so allow a small slack
   function automatic logic signed [15:0] near(logic signed [15:0] g, int e, int t);
      if ((^g !== 1'bx) && (g - e <= t) && (e - g <= t)) return 16'(e);
      return g;
   endfunction
   task automatic test_done();
      if (n_fail == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cfg(input logic c, input logic [3:0] m);
      {conv_s, comb_s, cfg_w} = {c, m, 1'b1};
      @(negedge clock_i);
      cfg_w = 1'b0;
      cv = c;
      if (m <= COMB_FB2) code = m;
      repeat (2) @(negedge clock_i);
      `chk(warn, cv && (code == COMB_ZMIN || code == COMB_ZMAX))
   endtask
   task automatic take(input int p1, p2, q1, q2, s1, s2, r);
      int f1, f2, fb, rf, d1, d2, t;
      bit z;
      k = 0;
      while (s_rdy !== 1'b1 && k < 60) begin
         @(negedge clock_i);
         k++;
      end
      if (k == 60) begin
         if (!fill) n_fail++;
         if (!fill) test_done();
         return;
      end
      if (code == COMB_ZMIN || code == COMB_ZMAX) {p1, p2} = 64'h0;
      {b1, b2, a1, a2} = {16'(p1), 16'(p2), 12'(q1), 12'(q2)};
      {sp1, sp2, rr, stb} = {16'(s1), 16'(s2), 16'(r), 1'b1};
      y1 += alpha / 65536.0 * (sat(p1 + ((q1 * int'(g1)) >> 8)) - y1);
      y2 += alpha / 65536.0 * (sat(p2 + ((q2 * int'(g2)) >> 8)) - y2);
      f1 = int'($floor(y1));
      f2 = int'($floor(y2));
      if (cv) begin
         f1 = (f1 < 0) ? 0 : int'($floor($sqrt(f1 * 32768.0)));
         f2 = (f2 < 0) ? 0 : int'($floor($sqrt(f2 * 32768.0)));
      end
      t = cv ? 16 : 4;
      d1 = s1 - f1;
      d2 = s2 - f2;
      z = (code == COMB_ZMIN) ? (d1 >= d2) : (d1 <= d2);
      rf = s1;
      case (code)
         COMB_MIN: fb = (f1 < f2) ? f1 : f2;
         COMB_MAX: fb = (f1 > f2) ? f1 : f2;
         COMB_SUM: fb = sat(f1 + f2);
         COMB_DIFF: fb = sat(f2 - f1);
         COMB_AVG: fb = (f1 + f2) >>> 1;
         COMB_FB1: fb = f1;
         COMB_FB2: {fb, rf} = {f2, s2};
         default: begin
            {fb, rf} = z ? {f1, s1} : {f2, s2};
            if (d1 - d2 <= t && d2 - d1 <= t) t = -1;
         end
      endcase
      exp_q.push_back({16'(fb), 16'(sat(r + rf))});
      tol_q.push_back(t);
      @(negedge clock_i);
      stb = 1'b0;
   endtask
   task automatic drain(input int cnt);
      logic [31:0] g;
      int t;
      repeat (cnt) begin
         k = 0;
         while (u_pid.got_q.size() == 0 && k < 200) begin
            @(negedge clock_i);
            k++;
         end
         if (k == 200) n_fail++;
         if (k == 200) test_done();
         g = u_pid.got_q.pop_front();
         t = tol_q.pop_front();
         if (t >= 0) `chk(near(g[31:16], $signed(exp_q[0][31:16]), t), exp_q[0][31:16])
         if (t >= 0) `chk(g[15:0], exp_q[0][15:0])
         void'(exp_q.pop_front());
      end
   endtask
   task automatic do_reset();
      rst_n_i = 1'b0;
      repeat (3) @(negedge clock_i);
      rst_n_i = 1'b1;
      y1 = 0.0;
      y2 = 0.0;
      {cv, code} = {1'b0, COMB_MAX};
      exp_q.delete();
      tol_q.delete();
      @(negedge clock_i);
   endtask
   initial begin
      forever #2 clock_i = ~clock_i;
   end
   initial begin
      do_reset();
      `chk(s_rdy, 1'b1)
      take(100, -50, 800, 400, 300, 0, 10);
      drain(1);
      for (int i = 0; i < 18; i++) begin
         cfg(i[0], 4'(i >> 1));
         mode = 2'($random(seed)) & 2'h1;
         repeat (3) begin
            {g1, g2} = {16'($random(seed)) & 16'h01ff, 16'($random(seed)) & 16'h01ff};
            take($random(seed) % 8000, $random(seed) % 8000, $random(seed) & 4095,
               $random(seed) & 4095, $random(seed) % 16000, $random(seed) % 16000,
               $random(seed) % 8000);
         end
         drain(3);
      end
      {g1, g2} = {16'h0100, 16'h0100};
      cfg(1'b0, COMB_SUM);
      cfg(1'b1, 4'h9);
      take(1000, 500, 0, 0, 0, 0, 0);
      drain(1);
      foreach (crn[r]) begin
         cfg(1'b0, 4'(crn[r][0]));
         take(crn[r][1], crn[r][2], crn[r][3], crn[r][4], crn[r][5], crn[r][6], crn[r][7]);
         drain(1);
      end
      {mode, fill} = {2'h2, 1'b1};
      while (k < 60 && n < 16) begin
         n++;
         take(n * 300, -100, 0, 0, 0, 0, n);
      end
      `chk(n - 1, 10)
      stb = 1'b1;
      @(negedge clock_i);
      stb = 1'b0;
      `chk(drop, 1'b1)
      `chk(near(disp, $signed(exp_q[$][31:16]), 4), exp_q[$][31:16])
      {mode, fill} = {2'h1, 1'b0};
      drain(10);
      take(5000, 0, 0, 0, 0, 0, 0);
      do_reset();
      {alpha, mode} = {16'h1000, 2'h0};
      repeat (4) take(1600, -1600, 0, 0, 0, 0, 0);
      drain(4);
      test_done();
   end
endmodule // pidfc_top_tb_top
